// [shared/ppt_pkg.sv]
// constants, carrier types and field layout of the positioning target block
// assumes an APB slave on one 25 MHz clock and quadrature feedback pins
package ppt_pkg;

  localparam int unsigned AW = 18;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_ITP  = 16'h5EF8;
  localparam logic [15:0] IDX_ZERO = 16'h5EFC;
  localparam logic [15:0] IDX_SSP  = 16'h6063;
  localparam logic [15:0] IDX_ACT  = 16'h6064;
  localparam logic [15:0] IDX_TPS  = 16'h607A;
  localparam logic [15:0] IDX_CTRL = 16'h5F00;
  localparam logic [15:0] IDX_HOME = 16'h5F01;
  localparam logic [15:0] IDX_RMIN = 16'h5F02;
  localparam logic [15:0] IDX_SHFT = 16'h5F03;
  localparam logic [15:0] IDX_STEP = 16'h5F04;
  localparam logic [15:0] IDX_STAT = 16'h5F05;

  // control word fields
  localparam int unsigned CTL_NEW  = 0;
  localparam int unsigned CTL_ABS  = 1;
  localparam int unsigned CTL_EN   = 2;
  localparam int unsigned CTL_CIRC = 3;
  localparam int unsigned CTL_CSP  = 4;
  localparam int unsigned CTL_W    = 5;

  // status fields
  localparam int unsigned STA_REACH = 0;
  localparam int unsigned STA_MOVE  = 1;

  localparam logic [31:0]      RST_POS   = 32'h0000_0000;
  localparam logic [CTL_W-1:0] RST_CTRL  = 5'h02;
  localparam logic [4:0]       RST_SHIFT = 5'h00;
  localparam logic [15:0]      RST_STEP  = 16'h0019;
  localparam int unsigned      ZERO_W    = 8;

  // encoder pulse pair
  typedef struct packed {
    logic up;
    logic dn;
  } ppt_enc_t;

  typedef enum logic [1:0] {
    PPT_IDLE  = 2'b00,
    PPT_PULSE = 2'b01,
    PPT_GAP   = 2'b11
  } ppt_step_st_t;

  function automatic logic ppt_hit(input logic [AW-1:0] a, input logic [15:0] idx);
    ppt_hit = (a == {idx, 2'b00});
  endfunction

endpackage

// [rtl/ppt_qdec.sv]
// quadrature decoder for the axis feedback sensor
// assumes enc_a/enc_b are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module ppt_qdec
  import ppt_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire logic     enc_a,
  input  wire logic     enc_b,
  output ppt_enc_t      pulse
);

  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] old_q;
  logic       fwd;
  logic       rev;

  // x4 decode: forward when new a equals old b inverted
  assign fwd = (s2_q != old_q) && (s2_q[1] != old_q[0]) && (s2_q[0] == old_q[1]);
  assign rev = (s2_q != old_q) && (s2_q[1] == old_q[0]) && (s2_q[0] != old_q[1]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q  <= 2'h0;
      s2_q  <= 2'h0;
      old_q <= 2'h0;
      pulse <= '0;
    end
    else
    begin
      s1_q     <= {enc_a, enc_b};
      s2_q     <= s1_q;
      old_q    <= s2_q;
      pulse.up <= fwd;
      pulse.dn <= rev;
    end
  end

endmodule
`default_nettype wire

// [rtl/ppt_step_gen.sv]
// step and direction pulse generator with programmable period
// assumes period from a register on the same clock
`timescale 1ns/1ps
`default_nettype none
module ppt_step_gen
  import ppt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic        dir_up,
  input  wire logic [15:0] period,
  output logic             step_o,
  output logic             dir_o,
  output logic             busy_o
);

  ppt_step_st_t st_q;
  ppt_step_st_t st_d;
  logic [15:0]  div_q;
  logic         tick;

  // one-cycle enable from the divider every period+1 cycles; period zero ticks every cycle
  assign tick = (div_q == 16'h0000);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      PPT_IDLE:  if (tick && run) st_d = PPT_PULSE;
      PPT_PULSE: if (tick) st_d = PPT_GAP;
      PPT_GAP:   if (tick) st_d = PPT_IDLE;
      default:   st_d = PPT_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q   <= PPT_IDLE;
      div_q  <= 16'h0000;
      step_o <= 1'b0;
      dir_o  <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      div_q  <= tick ? period : div_q - 16'h0001;
      step_o <= (st_d == PPT_PULSE);
      busy_o <= (st_d != PPT_IDLE);
      // direction only changes between steps
      if (st_q == PPT_IDLE)
        dir_o <= dir_up;
    end
  end

endmodule
`default_nettype wire

// [rtl/ppt_target_regs.sv]
// position setpoint and feedback registers of one servo axis, APB slave
// assumes APB master on pclk, quadrature feedback pins, step/dir power stage
`timescale 1ns/1ps
`default_nettype none
module ppt_target_regs
  import ppt_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          enc_a,
  input  wire logic          enc_b,
  output logic               step_o,
  output logic               dir_o,
  output logic               reached_o
);

  logic [31:0]      tps_q;
  logic [31:0]      itp_q;
  logic [31:0]      itp_d;
  logic [31:0]      pos_q;
  logic [31:0]      pos_d;
  logic [31:0]      home_q;
  logic [31:0]      rmin_q;
  logic [CTL_W-1:0] ctrl_q;
  logic             new_prev_q;
  logic [4:0]       shift_q;
  logic [15:0]      step_q;
  ppt_enc_t         enc;
  logic             busy;

  // bus decode
  logic        setup;
  logic        fire;
  logic        wr;
  logic        rd_setup;
  logic        h_itp;
  logic        h_zero;
  logic        h_ssp;
  logic        h_act;
  logic        h_tps;
  logic        h_ctrl;
  logic        h_home;
  logic        h_rmin;
  logic        h_shft;
  logic        h_step;
  logic        h_stat;
  logic        mapped;
  logic [31:0] rd_mux;

  assign setup    = psel && !penable && !pready;
  assign fire     = psel && penable && pready;
  assign wr       = fire && pwrite;
  assign rd_setup = setup && !pwrite;
  assign h_itp    = ppt_hit(paddr, IDX_ITP);
  assign h_zero   = ppt_hit(paddr, IDX_ZERO);
  assign h_ssp    = ppt_hit(paddr, IDX_SSP);
  assign h_act    = ppt_hit(paddr, IDX_ACT);
  assign h_tps    = ppt_hit(paddr, IDX_TPS);
  assign h_ctrl   = ppt_hit(paddr, IDX_CTRL);
  assign h_home   = ppt_hit(paddr, IDX_HOME);
  assign h_rmin   = ppt_hit(paddr, IDX_RMIN);
  assign h_shft   = ppt_hit(paddr, IDX_SHFT);
  assign h_step   = ppt_hit(paddr, IDX_STEP);
  assign h_stat   = ppt_hit(paddr, IDX_STAT);
  assign mapped   = h_itp | h_zero | h_ssp | h_act | h_tps | h_ctrl | h_home
                  | h_rmin | h_shft | h_step | h_stat;

  // position views
  logic [31:0] user_pos;
  logic [31:0] cmp_pos;
  logic        at_target;
  logic        accept;
  logic        zero_wr;

  // power-of-two scaling keeps the raw step view free of the factor
  assign user_pos  = 32'($signed(pos_q) >>> shift_q);
  // cyclic mode compares in raw steps, point-to-point in user units
  assign cmp_pos   = ctrl_q[CTL_CSP] ? pos_q : user_pos;
  assign at_target = (cmp_pos == itp_q);
  assign accept    = ctrl_q[CTL_NEW] && !new_prev_q && ctrl_q[CTL_EN];
  assign zero_wr   = wr && h_zero;

  assign rd_mux = h_itp  ? itp_q :
                  h_ssp  ? pos_q :
                  h_act  ? user_pos :
                  h_tps  ? tps_q :
                  h_ctrl ? {27'h0, ctrl_q} :
                  h_home ? home_q :
                  h_rmin ? rmin_q :
                  h_shft ? {27'h0, shift_q} :
                  h_step ? {16'h0000, step_q} :
                  h_stat ? {30'h0, busy, at_target} :
                  32'h0000_0000;

  // absolute load or relative accumulation, once per trigger
  assign itp_d = !accept          ? itp_q :
                 ctrl_q[CTL_ABS] ? tps_q :
                 itp_q + tps_q;

  // zeroing beats a concurrent encoder edge; circular adds range minimum
  assign pos_d = zero_wr ? (ctrl_q[CTL_CIRC] ? rmin_q + home_q : home_q) :
                 enc.up  ? pos_q + 32'h0000_0001 :
                 enc.dn  ? pos_q - 32'h0000_0001 :
                 pos_q;

  // bus answer: data latched in setup, ready one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (rd_setup)
        prdata <= rd_mux;
    end
  end

  // software-written registers; writes to read-only views are ignored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tps_q   <= RST_POS;
      ctrl_q  <= RST_CTRL;
      home_q  <= RST_POS;
      rmin_q  <= RST_POS;
      shift_q <= RST_SHIFT;
      step_q  <= RST_STEP;
    end
    else if (wr)
    begin
      if (h_tps)
        tps_q <= pwdata;
      if (h_ctrl)
        ctrl_q <= pwdata[CTL_W-1:0];
      if (h_home)
        home_q <= pwdata;
      if (h_rmin)
        rmin_q <= pwdata;
      if (h_shft)
        shift_q <= pwdata[4:0];
      if (h_step)
        step_q <= pwdata[15:0];
    end
  end

  // axis state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      itp_q      <= RST_POS;
      pos_q      <= RST_POS;
      new_prev_q <= 1'b0;
      reached_o  <= 1'b1;
    end
    else
    begin
      itp_q      <= itp_d;
      pos_q      <= pos_d;
      new_prev_q <= ctrl_q[CTL_NEW];
      reached_o  <= at_target;
    end
  end

  ppt_qdec u_qdec (
    .pclk    (pclk),
    .presetn (presetn),
    .enc_a   (enc_a),
    .enc_b   (enc_b),
    .pulse   (enc)
  );

  // keep stepping until the fed-back position meets the target
  ppt_step_gen u_step (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (ctrl_q[CTL_EN] && !at_target),
    .dir_up  ($signed(itp_q) > $signed(cmp_pos)),
    .period  (step_q),
    .step_o  (step_o),
    .dir_o   (dir_o),
    .busy_o  (busy)
  );

  // checks
  property p_abs_load;
    @(posedge pclk) disable iff (!presetn)
    accept && ctrl_q[CTL_ABS] |=> itp_q == $past(tps_q);
  endproperty
  a_abs_load: assert property (p_abs_load) else $error("absolute load wrong");

  property p_rel_load;
    @(posedge pclk) disable iff (!presetn)
    accept && !ctrl_q[CTL_ABS] |=> itp_q == $past(itp_q) + $past(tps_q);
  endproperty
  a_rel_load: assert property (p_rel_load) else $error("relative sum wrong");

  property p_hold_target;
    @(posedge pclk) disable iff (!presetn)
    !accept |=> $stable(itp_q);
  endproperty
  a_hold_target: assert property (p_hold_target) else $error("target moved untriggered");

  property p_once_per_trigger;
    @(posedge pclk) disable iff (!presetn)
    accept |=> !accept;
  endproperty
  a_once_per_trigger: assert property (p_once_per_trigger) else $error("double accept");

  property p_zero_lin;
    @(posedge pclk) disable iff (!presetn)
    zero_wr && !ctrl_q[CTL_CIRC] |=> pos_q == $past(home_q);
  endproperty
  a_zero_lin: assert property (p_zero_lin) else $error("linear zeroing wrong");

  property p_zero_circ;
    @(posedge pclk) disable iff (!presetn)
    zero_wr && ctrl_q[CTL_CIRC] |=> pos_q == $past(rmin_q) + $past(home_q);
  endproperty
  a_zero_circ: assert property (p_zero_circ) else $error("circular zeroing wrong");

  property p_zero_reads_zero;
    @(posedge pclk) disable iff (!presetn)
    rd_setup && h_zero |=> pready && prdata == 32'h0000_0000;
  endproperty
  a_zero_reads_zero: assert property (p_zero_reads_zero) else $error("zeroing readable");

  property p_read_target;
    @(posedge pclk) disable iff (!presetn)
    rd_setup && h_tps |=> prdata == $past(tps_q);
  endproperty
  a_read_target: assert property (p_read_target) else $error("target read wrong");

  property p_read_internal;
    @(posedge pclk) disable iff (!presetn)
    rd_setup && h_itp |=> prdata == $past(itp_q);
  endproperty
  a_read_internal: assert property (p_read_internal) else $error("internal read wrong");

  property p_read_sensor;
    @(posedge pclk) disable iff (!presetn)
    rd_setup && h_ssp |=> prdata == $past(pos_q);
  endproperty
  a_read_sensor: assert property (p_read_sensor) else $error("sensor read wrong");

  property p_read_actual;
    @(posedge pclk) disable iff (!presetn)
    rd_setup && h_act |=> prdata == 32'($signed($past(pos_q)) >>> $past(shift_q));
  endproperty
  a_read_actual: assert property (p_read_actual) else $error("actual read wrong");

  property p_no_step_at_target;
    @(posedge pclk) disable iff (!presetn)
    at_target && !busy |=> !step_o;
  endproperty
  a_no_step_at_target: assert property (p_no_step_at_target) else $error("step at target");

  property p_ptp_mode;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q[CTL_CSP] |=> reached_o == ($past(user_pos) == $past(itp_q));
  endproperty
  a_ptp_mode: assert property (p_ptp_mode) else $error("mode compare wrong");

  c_abs_move: cover property (@(posedge pclk) accept && ctrl_q[CTL_ABS]);
  c_rel_move: cover property (@(posedge pclk) accept && !ctrl_q[CTL_ABS]);
  c_zeroing:  cover property (@(posedge pclk) zero_wr && ctrl_q[CTL_CIRC]);
  c_arrive:   cover property (@(posedge pclk) busy ##[1:200] at_target);

endmodule
`default_nettype wire

// [tb/ppt_axis_plant.sv]
// axis plant: motor and quadrature sensor behind the step/dir stage
// assumes one sensor phase change per step pulse, jog for hand motion
`timescale 1ns/1ps
`default_nettype none
module ppt_axis_plant (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic step_i,
  input  wire logic dir_i,
  input  wire logic jog,
  input  wire logic jog_up,
  output logic      enc_a,
  output logic      enc_b
);
  logic [1:0] ph_q;
  logic       step_q;
  logic       adv;
  logic       up;
  assign adv = (step_i && !step_q) || jog;
  assign up  = jog ? jog_up : dir_i;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_q   <= 2'h0;
      step_q <= 1'h0;
    end
    else
    begin
      step_q <= step_i;
      if (adv)
        ph_q <= up ? ph_q + 2'h1 : ph_q - 2'h1;
    end
  end
  // gray order keeps a ahead of b when counting up
  assign enc_a = ph_q[1] ^ ph_q[0];
  assign enc_b = ph_q[1];
endmodule
`default_nettype wire

// [tb/ppt_target_regs_bench.sv]
// self-checking bench of the positioning target registers
// assumes the plant model closes the step to sensor loop
`timescale 1ns/1ps
`default_nettype none
module ppt_target_regs_bench
  import ppt_pkg::*;
();
  localparam int LIMIT = 40000;
  logic          pclk, presetn, psel, penable, pwrite, jog, jog_up;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, rd, exp_pos, t, h, r;
  logic          pready, pslverr, enc_a, enc_b, step_o, dir_o, reached_o, err;
  int            failures, cmp_count, cyc, i;
  logic [15:0]   ridx [8];
  logic [31:0]   rval [8];

  ppt_target_regs i_ppt_target_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a),
    .enc_b(enc_b), .step_o(step_o), .dir_o(dir_o), .reached_o(reached_o));
  ppt_axis_plant i_ppt_axis_plant (.pclk(pclk), .presetn(presetn), .step_i(step_o),
    .dir_i(dir_o), .jog(jog), .jog_up(jog_up), .enc_a(enc_a), .enc_b(enc_b));

  always #20 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      failures++;
      $display("unexpected at %0t: run hung", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // holds the request until pready is seen high, then releases it
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= {idx, 2'h0};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // no local limit: only the bench timeout ends a hung wait
    while (pready !== 1'h1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input string what);
    apb(1'h0, idx, 32'h0);
    chk(rd, exp, what);
  endtask

  // new bit pulsed, then wait until status shows reached and idle
  task automatic trig(input logic [31:0] base);
    apb(1'h1, IDX_CTRL, base | 32'h1);
    apb(1'h1, IDX_CTRL, base);
    repeat (4) @(posedge pclk);
    apb(1'h0, IDX_STAT, 32'h0);
    while (!(rd[0] === 1'h1 && rd[1] === 1'h0))
    begin
      apb(1'h0, IDX_STAT, 32'h0);
    end
  endtask

  // spaced apart so the synchroniser sees every phase
  task automatic jog_by(input logic dir);
    @(posedge pclk);
    jog    <= 1'h1;
    jog_up <= dir;
    @(posedge pclk);
    jog <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask

  function automatic logic [31:0] rel_sum(input logic [31:0] a, input logic [31:0] b);
    return a + b;
  endfunction

  function automatic logic [31:0] to_user(input logic [31:0] s, input int sh);
    return $signed(s) >>> sh;
  endfunction

  initial
  begin
    pclk = 1'h0;
    presetn = 1'h0;
    {psel, penable, pwrite, jog, jog_up} = 5'h00;
    paddr = '0;
    pwdata = 32'h0;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    ridx = '{IDX_TPS, IDX_ITP, IDX_ACT, IDX_SSP, IDX_ZERO, IDX_CTRL, IDX_STEP, IDX_SHFT};
    rval = '{RST_POS, RST_POS, RST_POS, RST_POS, 32'h0, {27'h0, RST_CTRL},
             {16'h0, RST_STEP}, 32'h0};
    void'($urandom(32'hE526));
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    for (i = 0; i < 8; i++)
      rdc(ridx[i], rval[i], "reset value");
    t = $urandom;
    apb(1'h1, IDX_TPS, t);
    rdc(IDX_TPS, t, "target readback");
    apb(1'h1, IDX_ITP, ~t);
    rdc(IDX_ITP, RST_POS, "internal target untouched");
    rdc(IDX_ACT, RST_POS, "no motion without trigger");
    apb(1'h0, 16'h1234, 32'h0);
    chk({rd[30:0], err}, 32'h1, "unmapped read");
    $display("test idle done");
    apb(1'h1, IDX_STEP, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      // first target equals the present position
      t = (i == 0) ? 32'h0 : $urandom_range(40) - 20;
      apb(1'h1, IDX_TPS, t);
      trig(32'h6);
      rdc(IDX_ITP, t, "absolute load");
      rdc(IDX_ACT, t, "position after absolute move");
      rdc(IDX_SSP, t, "steps after absolute move");
      chk({31'h0, reached_o}, 32'h1, "reached flag after move");
    end
    exp_pos = t;
    $display("test absolute done");
    for (i = 0; i < 3; i++)
    begin
      t = $urandom_range(20) - 10;
      apb(1'h1, IDX_TPS, t);
      trig(32'h4);
      exp_pos = rel_sum(exp_pos, t);
      rdc(IDX_ITP, exp_pos, "relative sum");
      rdc(IDX_ACT, exp_pos, "position after relative move");
    end
    $display("test relative done");
    // disable first: a new scaling while enabled would start a move
    apb(1'h1, IDX_CTRL, 32'h2);
    apb(1'h1, IDX_SHFT, 32'h2);
    rdc(IDX_ACT, to_user(exp_pos, 2), "scaled position");
    rdc(IDX_SSP, exp_pos, "steps ignore scaling");
    t = exp_pos + $urandom_range(16) - 8;
    apb(1'h1, IDX_TPS, t);
    trig(32'h16);
    rdc(IDX_SSP, t, "cyclic target in steps");
    rdc(IDX_ACT, to_user(t, 2), "cyclic user position");
    apb(1'h1, IDX_SHFT, 32'h0);
    $display("test scaling done");
    apb(1'h1, IDX_CTRL, 32'h0);
    h = $urandom_range(15);
    apb(1'h1, IDX_HOME, h);
    apb(1'h1, IDX_ZERO, $urandom);
    rdc(IDX_SSP, h, "linear zeroing");
    rdc(IDX_ACT, h, "linear zeroing user");
    rdc(IDX_ZERO, 32'h0, "zeroing reads nothing");
    apb(1'h1, IDX_CTRL, 32'h8);
    r = $urandom_range(15);
    apb(1'h1, IDX_RMIN, r);
    apb(1'h1, IDX_ZERO, 32'h0);
    rdc(IDX_SSP, r + h, "circular zeroing");
    $display("test zeroing done");
    jog_by(1'h1);
    jog_by(1'h1);
    jog_by(1'h1);
    jog_by(1'h0);
    repeat (8) @(posedge pclk);
    rdc(IDX_SSP, r + h + 32'h2, "hand motion steps");
    rdc(IDX_ACT, r + h + 32'h2, "hand motion user");
    $display("test hand motion done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
